//--- rtl/sfmc_consts.vh
// constants for the serial flash multilane command front end
`ifndef SFMC_CONSTS_VH
`define SFMC_CONSTS_VH

// opcodes
`define SFMC_OP_READ 8'h03
`define SFMC_OP_FREAD 8'h0b
`define SFMC_OP_SECRD 8'h48
`define SFMC_OP_DOUT 8'h3b
`define SFMC_OP_DIO 8'hbb
`define SFMC_OP_DID 8'h92
`define SFMC_OP_QOUT 8'h6b
`define SFMC_OP_QIO 8'heb
`define SFMC_OP_QID 8'h94
`define SFMC_OP_WRAP 8'h77
`define SFMC_OP_RDSR1 8'h05
`define SFMC_OP_RDSR2 8'h35
`define SFMC_OP_RDSR3 8'h15
`define SFMC_OP_WREN 8'h06
`define SFMC_OP_WRDI 8'h04
`define SFMC_OP_VWREN 8'h50
`define SFMC_OP_PP 8'h02
`define SFMC_OP_QPP 8'h32
`define SFMC_OP_SECPP 8'h42
`define SFMC_OP_SE 8'h20
`define SFMC_OP_BE32 8'h52
`define SFMC_OP_BE64 8'hd8
`define SFMC_OP_SECER 8'h44
`define SFMC_OP_CE1 8'hc7
`define SFMC_OP_CE2 8'h60
`define SFMC_OP_WRSR1 8'h01
`define SFMC_OP_WRSR2 8'h31
`define SFMC_OP_WRSR3 8'h11

// lane width codes
`define SFMC_LW1 2'd0
`define SFMC_LW2 2'd1
`define SFMC_LW4 2'd2

// data direction
`define SFMC_DIR_NONE 2'd0
`define SFMC_DIR_OUT 2'd1
`define SFMC_DIR_IN 2'd2

// output data source
`define SFMC_SRC_MEM 2'd0
`define SFMC_SRC_STAT 2'd1
`define SFMC_SRC_ID 2'd2

// phase lengths in bits or clocks
`define SFMC_ADDR_BITS 5'd24
`define SFMC_MODE_BITS 5'd8
`define SFMC_DUM_1LANE 4'd8
`define SFMC_DUM_QIO 4'd4

// security register selection
`define SFMC_SEC_HI 8'h00
`define SFMC_SEC_R1 8'h10
`define SFMC_SEC_R2 8'h20
`define SFMC_SEC_R3 8'h30

// read fill when the buffer runs dry
`define SFMC_FILL 8'hff

`endif

//--- rtl/sfmc_fifo.v
// read data buffer between array and serial output
`timescale 1ns/10ps
`default_nettype none
module sfmc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   input wire flush,
   // fill side
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output reg in_ready,
   // drain side
   output wire [WIDTH-1:0] out_data,
   output reg out_valid,
   input wire out_ready
);
localparam [31:0] DEPTH_W = DEPTH;
localparam [AW:0] FULL = DEPTH_W[AW:0];
reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wp;
reg [AW-1:0] rp;
reg [AW:0] cnt;
wire push = in_valid & in_ready;
wire pop = out_valid & out_ready;
wire [AW:0] next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
assign out_data = mem[rp];
always @(posedge clk)
begin
   if (push)
      mem[wp] <= in_data;
end
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
   end
   else if (flush)
   begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
   end
   else
   begin
      if (push)
         wp <= wp + 1'b1;
      if (pop)
         rp <= rp + 1'b1;
      cnt <= next_cnt;
      in_ready <= (next_cnt != FULL);
      out_valid <= (next_cnt != {(AW+1){1'b0}});
   end
end
endmodule
`default_nettype wire

//--- rtl/sfmc_front.v
// instruction front end of a multilane serial flash
`timescale 1ns/10ps
`default_nettype none
`include "sfmc_consts.vh"
module sfmc_front #(
   parameter [7:0] MFR_CODE = 8'h5a,
   parameter [7:0] DEV_CODE = 8'h3c
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   // serial pins
   input wire sck,
   input wire cs_n,
   input wire [3:0] lane_in,
   output reg [3:0] lane_out,
   output reg [3:0] lane_oe,
   // device state
   input wire busy,
   input wire quad_lane_enable,
   input wire op_done,
   input wire [7:0] status_1,
   input wire [7:0] status_2,
   input wire [7:0] status_3,
   // array read path
   output reg rd_active,
   output reg [23:0] rd_addr,
   input wire [7:0] rd_data,
   input wire rd_valid,
   output wire rd_ready,
   // command out
   output reg exec_strobe,
   output reg [7:0] exec_opcode,
   output reg [23:0] exec_addr,
   output reg exec_volatile,
   output reg [1:0] sec_reg_sel,
   // program data
   output reg prog_valid,
   output reg [7:0] prog_data,
   output reg [23:0] prog_addr,
   // flags
   output reg write_latch_flag,
   output reg vol_sr_enable,
   output reg [2:0] wrap_setting_bits,
   output reg [7:0] continuous_mode_byte
);
localparam [2:0] ST_CMD = 3'd0;
localparam [2:0] ST_ADDR = 3'd1;
localparam [2:0] ST_MODE = 3'd2;
localparam [2:0] ST_DUMMY = 3'd3;
localparam [2:0] ST_DOUT = 3'd4;
localparam [2:0] ST_DIN = 3'd5;
localparam [2:0] ST_DONE = 3'd6;

////////////////////////////////////////////////////////////////////////
// pin edges
reg sck_q;
reg cs_q;
wire rise = sck & ~sck_q & ~cs_n;
wire fall = ~sck & sck_q & ~cs_n;
wire cs_up = cs_n & ~cs_q;

reg [2:0] state;
reg [7:0] op;
reg [4:0] cnt;
reg [1:0] cur_w;
reg [23:0] addr;
reg [7:0] din;
reg [7:0] osr;
reg [3:0] ocnt;
reg ign;
reg got_byte;
reg id_sel;
reg [23:0] pbase;
reg [7:0] plow;
reg pop;
wire [7:0] fifo_data;
wire fifo_valid;

////////////////////////////////////////////////////////////////////////
// opcode decode
wire [7:0] op_in = (state == ST_CMD) ? {op[6:0], lane_in[0]} : op;
reg d_ok;
reg [1:0] d_aw;
reg d_addr;
reg d_mode;
reg [3:0] d_dum;
reg [1:0] d_dir;
reg [1:0] d_dw;
reg [1:0] d_src;
reg d_wr;
reg d_wrsr;
reg d_qe;
always @*
begin
   d_ok = 1'b1;
   d_aw = `SFMC_LW1;
   d_addr = 1'b0;
   d_mode = 1'b0;
   d_dum = 4'd0;
   d_dir = `SFMC_DIR_NONE;
   d_dw = `SFMC_LW1;
   d_src = `SFMC_SRC_MEM;
   d_wr = 1'b0;
   d_wrsr = 1'b0;
   d_qe = 1'b0;
   case (op_in)
      `SFMC_OP_READ:
      begin
         d_addr = 1'b1;
         d_dir = `SFMC_DIR_OUT;
      end
      `SFMC_OP_FREAD, `SFMC_OP_SECRD:
      begin
         d_addr = 1'b1;
         d_dum = `SFMC_DUM_1LANE;
         d_dir = `SFMC_DIR_OUT;
      end
      `SFMC_OP_DOUT:
      begin
         d_addr = 1'b1;
         d_dum = `SFMC_DUM_1LANE;
         d_dir = `SFMC_DIR_OUT;
         d_dw = `SFMC_LW2;
      end
      `SFMC_OP_DIO, `SFMC_OP_DID:
      begin
         d_aw = `SFMC_LW2;
         d_addr = 1'b1;
         d_mode = 1'b1;
         d_dir = `SFMC_DIR_OUT;
         d_dw = `SFMC_LW2;
         d_src = (op_in == `SFMC_OP_DID) ? `SFMC_SRC_ID : `SFMC_SRC_MEM;
      end
      `SFMC_OP_QOUT:
      begin
         d_addr = 1'b1;
         d_dum = `SFMC_DUM_1LANE;
         d_dir = `SFMC_DIR_OUT;
         d_dw = `SFMC_LW4;
         d_qe = 1'b1;
      end
      `SFMC_OP_QIO, `SFMC_OP_QID:
      begin
         d_aw = `SFMC_LW4;
         d_addr = 1'b1;
         d_mode = 1'b1;
         d_dum = `SFMC_DUM_QIO;
         d_dir = `SFMC_DIR_OUT;
         d_dw = `SFMC_LW4;
         d_src = (op_in == `SFMC_OP_QID) ? `SFMC_SRC_ID : `SFMC_SRC_MEM;
      end
      `SFMC_OP_WRAP:
      begin
         d_aw = `SFMC_LW4;
         d_addr = 1'b1;
         d_mode = 1'b1;
      end
      `SFMC_OP_RDSR1, `SFMC_OP_RDSR2, `SFMC_OP_RDSR3:
      begin
         d_dir = `SFMC_DIR_OUT;
         d_src = `SFMC_SRC_STAT;
      end
      `SFMC_OP_WREN, `SFMC_OP_WRDI, `SFMC_OP_VWREN:
         d_ok = 1'b1;
      `SFMC_OP_PP, `SFMC_OP_SECPP, `SFMC_OP_QPP:
      begin
         d_addr = 1'b1;
         d_dir = `SFMC_DIR_IN;
         d_dw = (op_in == `SFMC_OP_QPP) ? `SFMC_LW4 : `SFMC_LW1;
         d_wr = 1'b1;
      end
      `SFMC_OP_SE, `SFMC_OP_BE32, `SFMC_OP_BE64, `SFMC_OP_SECER:
      begin
         d_addr = 1'b1;
         d_wr = 1'b1;
      end
      `SFMC_OP_CE1, `SFMC_OP_CE2:
         d_wr = 1'b1;
      `SFMC_OP_WRSR1, `SFMC_OP_WRSR2, `SFMC_OP_WRSR3:
      begin
         d_dir = `SFMC_DIR_IN;
         d_wr = 1'b1;
         d_wrsr = 1'b1;
      end
      default:
         d_ok = 1'b0;
   endcase
end

////////////////////////////////////////////////////////////////////////
// phase sequencing
wire [2:0] after_dum = (d_dir == `SFMC_DIR_OUT) ? ST_DOUT : (d_dir == `SFMC_DIR_IN) ? ST_DIN : ST_DONE;
wire [2:0] after_mode = (d_dum != 4'd0) ? ST_DUMMY : after_dum;
wire [2:0] after_addr = d_mode ? ST_MODE : after_mode;
wire [2:0] after_cmd = d_addr ? ST_ADDR : after_addr;
wire [4:0] step = 5'd1 << cur_w;
wire [3:0] step4 = 4'd1 << cur_w;
wire [4:0] nb = cnt + step;
wire stat_cmd = (d_src == `SFMC_SRC_STAT) && (d_dir == `SFMC_DIR_OUT);

function [1:0] width_of;
   input [2:0] s;
   input [1:0] aw;
   input [1:0] dw;
   begin
      width_of = (s == ST_DOUT || s == ST_DIN) ? dw : aw;
   end
endfunction

// msb first shifting, lane 0 is the serial input pin
reg [23:0] addr_sh;
reg [7:0] mode_sh;
reg [7:0] din_sh;
always @*
begin
   case (cur_w)
      `SFMC_LW1:
      begin
         addr_sh = {addr[22:0], lane_in[0]};
         mode_sh = {continuous_mode_byte[6:0], lane_in[0]};
         din_sh = {din[6:0], lane_in[0]};
      end
      `SFMC_LW2:
      begin
         addr_sh = {addr[21:0], lane_in[1:0]};
         mode_sh = {continuous_mode_byte[5:0], lane_in[1:0]};
         din_sh = {din[5:0], lane_in[1:0]};
      end
      default:
      begin
         addr_sh = {addr[19:0], lane_in};
         mode_sh = {continuous_mode_byte[3:0], lane_in};
         din_sh = {din[3:0], lane_in};
      end
   endcase
end

////////////////////////////////////////////////////////////////////////
// output byte source
reg [7:0] nxt_byte;
always @*
begin
   case (d_src)
      `SFMC_SRC_STAT:
         nxt_byte = (op == `SFMC_OP_RDSR2) ? status_2 : (op == `SFMC_OP_RDSR3) ? status_3 : status_1;
      `SFMC_SRC_ID:
         nxt_byte = id_sel ? DEV_CODE : MFR_CODE;
      default:
         nxt_byte = fifo_valid ? fifo_data : `SFMC_FILL;
   endcase
end
wire [7:0] vout = (ocnt == 4'd0) ? nxt_byte : osr;

wire wr_end_ok = (state == ST_DONE || state == ST_DIN) && (d_dir != `SFMC_DIR_IN || got_byte);
wire [7:0] addr_hi = addr[23:16];
wire [1:0] sec_sel = (addr_hi != `SFMC_SEC_HI) ? 2'd0 :
   (addr[15:8] == `SFMC_SEC_R1) ? 2'd1 : (addr[15:8] == `SFMC_SEC_R2) ? 2'd2 :
   (addr[15:8] == `SFMC_SEC_R3) ? 2'd3 : 2'd0;

////////////////////////////////////////////////////////////////////////
// main sequencer
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      state <= ST_CMD;
      op <= 8'h00;
      cnt <= 5'd0;
      cur_w <= `SFMC_LW1;
      addr <= 24'h000000;
      din <= 8'h00;
      osr <= 8'h00;
      ocnt <= 4'd0;
      ign <= 1'b0;
      got_byte <= 1'b0;
      id_sel <= 1'b0;
      pbase <= 24'h000000;
      plow <= 8'h00;
      pop <= 1'b0;
      lane_out <= 4'h0;
      lane_oe <= 4'h0;
      rd_active <= 1'b0;
      rd_addr <= 24'h000000;
      exec_strobe <= 1'b0;
      exec_opcode <= 8'h00;
      exec_addr <= 24'h000000;
      exec_volatile <= 1'b0;
      sec_reg_sel <= 2'd0;
      prog_valid <= 1'b0;
      prog_data <= 8'h00;
      prog_addr <= 24'h000000;
      write_latch_flag <= 1'b0;
      vol_sr_enable <= 1'b0;
      wrap_setting_bits <= 3'h0;
      continuous_mode_byte <= 8'h00;
   end
   else
   begin
      sck_q <= sck;
      cs_q <= cs_n;
      exec_strobe <= 1'b0;
      prog_valid <= 1'b0;
      pop <= 1'b0;
      if (op_done)
         write_latch_flag <= 1'b0;
      if (cs_n)
      begin
         state <= ST_CMD;
         cnt <= 5'd0;
         cur_w <= `SFMC_LW1;
         ocnt <= 4'd0;
         ign <= 1'b0;
         got_byte <= 1'b0;
         id_sel <= 1'b0;
         lane_oe <= 4'h0;
         rd_active <= 1'b0;
      end
      // end of frame, whole bytes only
      if (cs_up && !ign && state != ST_CMD && cnt[2:0] == 3'b000)
      begin
         case (op)
            `SFMC_OP_WREN:
               write_latch_flag <= 1'b1;
            `SFMC_OP_WRDI:
               write_latch_flag <= 1'b0;
            `SFMC_OP_VWREN:
               vol_sr_enable <= 1'b1;
            `SFMC_OP_WRAP:
               if (state == ST_DONE)
                  wrap_setting_bits <= continuous_mode_byte[6:4];
            default:
               if (d_wr && wr_end_ok && (write_latch_flag || (d_wrsr && vol_sr_enable)))
               begin
                  exec_strobe <= 1'b1;
                  exec_opcode <= op;
                  exec_addr <= addr;
                  exec_volatile <= d_wrsr & ~write_latch_flag;
                  sec_reg_sel <= sec_sel;
                  if (d_wrsr)
                     vol_sr_enable <= 1'b0;
               end
         endcase
      end
      if (rise)
      begin
         case (state)
            ST_CMD:
            begin
               op <= op_in;
               cnt <= nb;
               if (cnt == 5'd7)
               begin
                  cnt <= 5'd0;
                  if (!d_ok || (busy && !stat_cmd) || (d_qe && !quad_lane_enable))
                  begin
                     ign <= 1'b1;
                     state <= ST_DONE;
                  end
                  else
                  begin
                     state <= after_cmd;
                     cur_w <= width_of(after_cmd, d_aw, d_dw);
                  end
               end
            end
            ST_ADDR:
            begin
               addr <= addr_sh;
               cnt <= nb;
               if (nb == `SFMC_ADDR_BITS)
               begin
                  cnt <= 5'd0;
                  state <= after_addr;
                  cur_w <= width_of(after_addr, d_aw, d_dw);
                  rd_active <= (d_dir == `SFMC_DIR_OUT) && (d_src == `SFMC_SRC_MEM);
                  rd_addr <= addr_sh;
                  pbase <= addr_sh;
                  plow <= addr_sh[7:0];
               end
            end
            ST_MODE:
            begin
               continuous_mode_byte <= mode_sh;
               cnt <= nb;
               if (nb == `SFMC_MODE_BITS)
               begin
                  cnt <= 5'd0;
                  state <= after_mode;
                  cur_w <= width_of(after_mode, d_aw, d_dw);
               end
            end
            ST_DUMMY:
            begin
               cnt <= cnt + 5'd1;
               if (cnt + 5'd1 == {1'b0, d_dum})
               begin
                  cnt <= 5'd0;
                  state <= after_dum;
                  cur_w <= width_of(after_dum, d_aw, d_dw);
               end
            end
            ST_DIN:
            begin
               din <= din_sh;
               cnt <= {2'b00, nb[2:0]};
               if (nb[2:0] == 3'b000)
               begin
                  prog_valid <= 1'b1;
                  prog_data <= din_sh;
                  prog_addr <= {pbase[23:8], plow};
                  plow <= plow + 8'h01;
                  got_byte <= 1'b1;
               end
            end
            ST_DONE:
               cnt <= {2'b00, nb[2:0]};
            default:
               cnt <= cnt;
         endcase
      end
      // drive on falling edges, only in the output phase
      if (fall && state == ST_DOUT)
      begin
         case (cur_w)
            `SFMC_LW1:
            begin
               lane_out <= {2'b00, vout[7], 1'b0};
               lane_oe <= 4'b0010;
            end
            `SFMC_LW2:
            begin
               lane_out <= {2'b00, vout[7:6]};
               lane_oe <= 4'b0011;
            end
            default:
            begin
               lane_out <= vout[7:4];
               lane_oe <= 4'b1111;
            end
         endcase
         osr <= vout << step;
         if (ocnt == 4'd0)
         begin
            ocnt <= 4'd8 - step4;
            id_sel <= ~id_sel;
            pop <= (d_src == `SFMC_SRC_MEM) & fifo_valid;
         end
         else
            ocnt <= ocnt - step4;
      end
   end
end

////////////////////////////////////////////////////////////////////////
// read buffer
sfmc_fifo #(
   .WIDTH(8),
   .DEPTH(16),
   .AW(4)
) u_fifo (
   .clk(clk),
   .rstn(rstn),
   .flush(cs_n),
   .in_data(rd_data),
   .in_valid(rd_valid),
   .in_ready(rd_ready),
   .out_data(fifo_data),
   .out_valid(fifo_valid),
   .out_ready(pop)
);
endmodule
`default_nettype wire

//--- testbench/sfmc_host.sv
// host controller model driving select, serial clock and lanes
`timescale 1ns/10ps
`default_nettype none
module sfmc_host (
   // clock
   input wire logic clk,
   // serial pins
   input wire logic [3:0] lane_out,
   output logic sck,
   output logic cs_n,
   output logic [3:0] lane_in
);
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      lane_in = 4'h0;
   end
   // clock stands still outside frames, lanes set while low
   task pulse(input logic [3:0] v, output logic [3:0] o);
      @(negedge clk) lane_in = v;
      repeat (2) @(negedge clk);
      o = lane_out;
      sck = 1'b1;
      repeat (3) @(negedge clk);
      sck = 1'b0;
   endtask
   // top bits leave first, top lane carries the highest bit
   task send(input logic [31:0] d, input int clks, input int w);
      logic [3:0] o;
      for (int i = 0; i < clks; i++)
      begin
         pulse(4'(d >> (32 - w)), o);
         d = d << w;
      end
   endtask
   // released lanes toggle so stale values never match
   task recv(input int clks, input int w, output logic [15:0] r);
      logic [3:0] o;
      r = 16'h0;
      for (int i = 0; i < clks; i++)
      begin
         pulse(~lane_in, o);
         r = (r << w) | (w == 1 ? 16'(o[1]) : (w == 2 ? 16'(o[1:0]) : 16'(o)));
      end
   endtask
   task start;
      @(negedge clk) cs_n = 1'b0;
   endtask
   task stop;
      @(negedge clk) cs_n = 1'b1;
      repeat (4) @(negedge clk);
   endtask
endmodule
`default_nettype wire

//--- testbench/sfmc_props.sv
// port checker for the command front end
`timescale 1ns/10ps
`default_nettype none
module sfmc_props (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // serial pins
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] lane_out,
   input wire logic [3:0] lane_oe,
   // state and results
   input wire logic busy,
   input wire logic op_done,
   input wire logic exec_strobe,
   input wire logic exec_volatile,
   input wire logic prog_valid,
   input wire logic write_latch_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   sequence s_sck_fell;
      !$past(sck) && $past(sck, 2) && !$past(cs_n);
   endsequence
   sequence s_closed;
      cs_n && $past(cs_n);
   endsequence
   ////////////////////////////////////////
   property p_oe_drop;
      cs_n |-> ##2 lane_oe == 4'h0;
   endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("lanes driven after deselect");
   property p_oe_code;
      lane_oe == 4'h0 || lane_oe == 4'h2 || lane_oe == 4'h3 || lane_oe == 4'hf;
   endproperty
   a_oe_code: assert property (p_oe_code) else $error("lane drive pattern odd");
   property p_lane_hold;
      $changed(lane_out) |-> s_sck_fell;
   endproperty
   a_lane_hold: assert property (p_lane_hold) else $error("lane changed without fall");
   property p_strobe_closed;
      exec_strobe |-> $past(cs_n) && !$past(cs_n, 2);
   endproperty
   a_strobe_closed: assert property (p_strobe_closed) else $error("strobe inside frame");
   property p_strobe_latch;
      exec_strobe && !exec_volatile |-> $past(write_latch_flag);
   endproperty
   a_strobe_latch: assert property (p_strobe_latch) else $error("write without latch");
   property p_latch_rise;
      $rose(write_latch_flag) |-> $past(cs_n) && !$past(cs_n, 2);
   endproperty
   a_latch_rise: assert property (p_latch_rise) else $error("latch set inside frame");
   property p_done_clear;
      op_done ##0 s_closed |-> ##2 !write_latch_flag;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("latch kept after done");
   property p_busy_quiet;
      busy && $past(busy, 3) |-> !exec_strobe && !$rose(write_latch_flag);
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("accepted while busy");
   property p_prog_gap;
      prog_valid |=> !prog_valid [*3];
   endproperty
   a_prog_gap: assert property (p_prog_gap) else $error("program bytes too close");
endmodule
bind sfmc_front sfmc_props i_props (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .lane_out(lane_out),
   .lane_oe(lane_oe), .busy(busy), .op_done(op_done), .exec_strobe(exec_strobe),
   .exec_volatile(exec_volatile), .prog_valid(prog_valid), .write_latch_flag(write_latch_flag));
`default_nettype wire

//--- testbench/tb_sfmc_front.sv
// self-checking bench for the command front end
`timescale 1ns/10ps
`default_nettype none
module tb_sfmc_front;
   localparam logic [7:0] MFR = 8'h5a; // arbitrary code
   localparam logic [7:0] DEV = 8'h3c; // arbitrary code
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic sck, cs_n, busy, quad_lane_enable, op_done, rd_active, rd_valid, rd_ready, taken;
   logic exec_strobe, exec_volatile, prog_valid, write_latch_flag, vol_sr_enable;
   logic [3:0] lane_in, lane_out, lane_oe;
   logic [7:0] st1, st2, st3, rd_data, exec_opcode, prog_data, continuous_mode_byte;
   logic [23:0] rd_addr, exec_addr, prog_addr;
   logic [1:0] sec_reg_sel;
   logic [2:0] wrap_setting_bits;
   int error_cnt = 0;
   int compares = 0;
   int ex_cnt = 0;
   int cyc = 0;
   always #4 clk = ~clk;
   sfmc_front #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_dut (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n),
      .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe), .busy(busy),
      .quad_lane_enable(quad_lane_enable), .op_done(op_done), .status_1(st1), .status_2(st2),
      .status_3(st3), .rd_active(rd_active), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .exec_strobe(exec_strobe), .exec_opcode(exec_opcode), .exec_addr(exec_addr),
      .exec_volatile(exec_volatile), .sec_reg_sel(sec_reg_sel), .prog_valid(prog_valid),
      .prog_data(prog_data), .prog_addr(prog_addr), .write_latch_flag(write_latch_flag),
      .vol_sr_enable(vol_sr_enable), .wrap_setting_bits(wrap_setting_bits),
      .continuous_mode_byte(continuous_mode_byte));
   sfmc_host i_host (.clk(clk), .lane_out(lane_out), .sck(sck), .cs_n(cs_n), .lane_in(lane_in));
   ////////////////////////////////////////
   // array streams bytes upward from the read start
   always @(posedge clk) taken <= rd_valid & rd_ready;
   always @(negedge clk)
   begin
      rd_valid <= rd_active;
      if (!rd_valid)
         rd_data <= rd_addr[7:0];
      else if (taken)
         rd_data <= rd_data + 8'h01;
   end
   always @(posedge clk)
   begin
      if (exec_strobe === 1'b1)
         ex_cnt <= ex_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         print_verdict;
      end
   end
   ////////////////////////////////////////
   task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task print_verdict;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task frame1(input logic [7:0] op);
      i_host.start;
      i_host.send({op, 24'h0}, 8, 1);
      i_host.stop;
   endtask
   ////////////////////////////////////////
   task t_latch;
      chk("latch at reset", 0, write_latch_flag);
      frame1(8'h06);
      chk("latch enable", 1, write_latch_flag);
      frame1(8'h04);
      chk("latch disable", 0, write_latch_flag);
      frame1(8'h50);
      chk("latch volatile", 0, write_latch_flag);
      chk("volatile enable", 1, vol_sr_enable);
      i_host.start;
      i_host.send({8'h01, 8'ha5, 16'h0}, 16, 1);
      i_host.stop;
      chk("volatile status write", 1, exec_volatile);
      chk("volatile enable spent", 0, vol_sr_enable);
      busy = 1'b1;
      frame1(8'h06);
      chk("latch busy", 0, write_latch_flag);
      busy = 1'b0;
      $display("test latch done");
   endtask
   task t_status;
      logic [15:0] r;
      logic [7:0] op [3];
      logic [7:0] ex [3];
      op = '{8'h05, 8'h35, 8'h15};
      ex = '{st1, st2, st3};
      busy = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         i_host.start;
         i_host.send({op[i], 24'h0}, 8, 1);
         i_host.recv(16, 1, r);
         chk("status drive", 4'h2, lane_oe);
         i_host.stop;
         chk("status bytes", {ex[i], ex[i]}, r);
      end
      busy = 1'b0;
      $display("test status done");
   endtask
   task t_qe;
      i_host.start;
      i_host.send(32'h6b000000, 8, 1);
      i_host.send(32'h0, 32, 1);
      chk("quad read refused", 0, rd_active);
      i_host.stop;
      quad_lane_enable = 1'b1;
      $display("test quad enable done");
   endtask
   task t_read(input logic [7:0] op, input logic [23:0] a, input int aw, md, dum, dw, id);
      logic [15:0] r;
      i_host.start;
      i_host.send({op, 24'h0}, 8, 1);
      i_host.send({a, 8'hf0}, (24 + 8 * md) / aw, aw);
      i_host.send(32'h0, dum, aw);
      i_host.recv(16 / dw, dw, r);
      if (id == 0)
      begin
         chk("read start", a, rd_addr);
         chk("buffer refuses", 0, rd_ready);
      end
      if (md == 1)
         chk("mode byte", 8'hf0, continuous_mode_byte);
      i_host.stop;
      chk("read bytes", id ? {MFR, DEV} : {a[7:0], a[7:0] + 8'h01}, r);
      $display("test read %h done", op);
   endtask
   task t_refuse;
      int c;
      c = ex_cnt;
      for (int k = 0; k < 2; k++)
      begin
         frame1(k ? 8'h06 : 8'h04);
         i_host.start;
         i_host.send(32'h02000000, 8, 1);
         i_host.send(32'h0, 32, 1);
         i_host.send(32'h0, 4 * k, 1);
         i_host.stop;
         chk("write refused", 24'(c), 24'(ex_cnt));
      end
      $display("test refuse done");
   endtask
   task t_prog(input logic [7:0] op, input logic [23:0] a, input int w, n, input logic [1:0] sel);
      int c;
      frame1(8'h06);
      c = ex_cnt;
      i_host.start;
      i_host.send({op, 24'h0}, 8, 1);
      i_host.send({a, 8'h0}, 24, 1);
      for (int i = 0; i < n; i++)
      begin
         i_host.send({8'(8'hc0 + i), 24'h0}, 8 / w, w);
         chk("program byte", 8'(8'hc0 + i), prog_data);
         chk("program address", {a[23:8], 8'(a[7:0] + i)}, prog_addr);
      end
      i_host.stop;
      chk("write accepted", 24'(c + 1), 24'(ex_cnt));
      chk("write opcode", op, exec_opcode);
      chk("write address", a, exec_addr);
      chk("security select", sel, sec_reg_sel);
      op_done = 1'b1;
      @(negedge clk) op_done = 1'b0;
      @(negedge clk);
      chk("latch after done", 0, write_latch_flag);
      $display("test program %h done", op);
   endtask
   task t_wrap;
      i_host.start;
      i_host.send(32'h77000000, 8, 1);
      i_host.send(32'h00000050, 8, 4);
      i_host.stop;
      chk("wrap setting", 3'b101, wrap_setting_bits);
      $display("test wrap done");
   endtask
   ////////////////////////////////////////
   initial
   begin
      busy = 1'b0;
      quad_lane_enable = 1'b0;
      op_done = 1'b0;
      st1 = 8'h96;
      st2 = 8'h4b;
      st3 = 8'hc3;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      t_latch;
      t_status;
      t_qe;
      t_read(8'h3b, 24'h00a110, 1, 0, 8, 2, 0);
      t_read(8'h6b, 24'h00b220, 1, 0, 8, 4, 0);
      t_read(8'hbb, 24'h5a5a33, 2, 1, 0, 2, 0);
      t_read(8'heb, 24'h3c0f41, 4, 1, 4, 4, 0);
      t_read(8'h92, 24'h120000, 2, 1, 0, 2, 1);
      t_read(8'h94, 24'h340000, 4, 1, 4, 4, 1);
      t_refuse;
      t_prog(8'h02, 24'h0123fe, 1, 3, 2'd0);
      t_prog(8'h32, 24'h004410, 4, 2, 2'd0);
      t_prog(8'h42, 24'h002005, 1, 1, 2'd2);
      t_wrap;
      print_verdict;
   end
endmodule
`default_nettype wire
